// ### hw/pbd_mux_map.vh
// Constants for the port B/D alternate function mux
// Assumes a 200 MHz system clock
`ifndef PBD_MUX_MAP_VH
`define PBD_MUX_MAP_VH
// Spike window: 50 ns at 5 ns a cycle, ten cycles exactly
`define PBD_SPIKE_CYC       4'hA
`define PBD_FILT_W          4
`define PBD_PORT_RST        8'h00
`define PBD_PIN_SCL         0
`define PBD_PIN_SDA         1
`define PBD_PIN_RXD         2
`define PBD_PIN_TXD         3
`define PBD_PIN_XCK         4
`define PBD_PIN_MISO        3
`define PBD_PIN_OC0         4
`define PBD_PIN_TIMER1_COMPARE_A_OUT        5
`define PBD_PIN_TIMER1_COMPARE_B_OUT        6
`define PBD_PIN_OC2         7
`endif

// ### hw/pbd_mux.v
// Alternate function pin mux for ports B and D
// Assumes pad inputs are asynchronous; peripheral controls come from sys_clk logic
`timescale 1ns/1ps
`include "pbd_mux_map.vh"
module pbd_mux (
   input  wire       sys_clk,
   input  wire       rst_n,
   input  wire [7:0] portb_dir,
   input  wire [7:0] portb_out,
   input  wire [7:0] portd_dir,
   input  wire [7:0] portd_out,
   input  wire [7:0] portb_pad_in,
   input  wire [7:0] portd_pad_in,
   input  wire       serial2_tx_en,
   input  wire       serial2_rx_en,
   input  wire       serial2_sync_mode,
   input  wire       serial2_tx_data,
   input  wire       serial2_clk_out,
   input  wire       two_wire_enable,
   input  wire       two_wire_sda_low,
   input  wire       two_wire_scl_low,
   input  wire       spi_enable,
   input  wire       spi_master,
   input  wire       spi_slave_out,
   input  wire       timer0_cmp_en,
   input  wire       timer0_compare_out,
   input  wire       timer1_cmp_a_en,
   input  wire       timer1_compare_a_out,
   input  wire       timer1_cmp_b_en,
   input  wire       timer1_compare_b_out,
   input  wire       timer1_cmp_c_en,
   input  wire       timer1_compare_c_out,
   input  wire       timer2_cmp_en,
   input  wire       timer2_compare_out,
   output reg  [7:0] portb_pad_out,
   output reg  [7:0] portb_pad_oe,
   output reg  [7:0] portb_pullup,
   output reg  [7:0] portd_pad_out,
   output reg  [7:0] portd_pad_oe,
   output reg  [7:0] portd_pullup,
   output reg  [7:0] portb_pin_val,
   output reg  [7:0] portd_pin_val,
   output reg  [3:0] ext_irq_line,
   output reg        serial2_rx_pin,
   output reg        serial2_ext_clock,
   output reg        timer1_capture_in,
   output reg        spi_master_in,
   output reg        two_wire_sda_in,
   output reg        two_wire_scl_in
);

   // Two-stage synchronisers for all pad inputs.
   // Logic reads only the second stage; the first may be metastable.
   reg  [7:0] pb_s1_reg;
   reg  [7:0] pb_s2_reg;
   reg  [7:0] pd_s1_reg;
   reg  [7:0] pd_s2_reg;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pb_s1_reg <= `PBD_PORT_RST;
         pb_s2_reg <= `PBD_PORT_RST;
         pd_s1_reg <= `PBD_PORT_RST;
         pd_s2_reg <= `PBD_PORT_RST;
      end else begin
         pb_s1_reg <= portb_pad_in;
         pb_s2_reg <= pb_s1_reg;
         pd_s1_reg <= portd_pad_in;
         pd_s2_reg <= pd_s1_reg;
      end
   end

   // Spike filter: a new level is accepted only after it holds the full window.
   // Costs ten cycles of latency on both lines, far below any bus bit time.
   // Any return to the old level restarts the count, so short bursts never pass.
   localparam [`PBD_FILT_W-1:0] SPIKE_CYC = `PBD_SPIKE_CYC;
   wire [1:0]               filt_in = pd_s2_reg[1:0];
   wire [1:0]               filt_lvl;
   genvar                   gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
         reg [`PBD_FILT_W-1:0] cnt_reg;
         // Idle high, as a released open-drain line
         reg                   lvl_reg;
         assign filt_lvl[gi] = lvl_reg;
         always @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               cnt_reg <= {`PBD_FILT_W{1'h0}};
               lvl_reg <= 1'h1;
            end else if (filt_in[gi] == lvl_reg) begin
               cnt_reg <= {`PBD_FILT_W{1'h0}};
            end else if (cnt_reg == SPIKE_CYC - 4'h1) begin
               cnt_reg <= {`PBD_FILT_W{1'h0}};
               lvl_reg <= filt_in[gi];
            end else begin
               cnt_reg <= cnt_reg + 4'h1;
            end
         end
      end
   endgenerate

   // Two-wire inputs read idle high while the interface is off,
   // so a disabled bus never looks like a start condition
   function tw_in;
      input en;
      input lvl;
      begin
         tw_in = en ? lvl : 1'h1;
      end
   endfunction

   reg [7:0] pb_out_next;
   reg [7:0] pb_oe_next;
   reg [7:0] pd_out_next;
   reg [7:0] pd_oe_next;
   wire      xck_active = serial2_sync_mode;

   always @* begin
      // Plain I/O unless a peripheral claims the pin
      pb_out_next = portb_out;
      pb_oe_next  = portb_dir;
      pd_out_next = portd_out;
      pd_oe_next  = portd_dir;
      // Compare outputs replace data but never the direction bit
      if (timer0_cmp_en)
         pb_out_next[`PBD_PIN_OC0] = timer0_compare_out;
      if (timer1_cmp_a_en)
         pb_out_next[`PBD_PIN_TIMER1_COMPARE_A_OUT] = timer1_compare_a_out;
      if (timer1_cmp_b_en)
         pb_out_next[`PBD_PIN_TIMER1_COMPARE_B_OUT] = timer1_compare_b_out;
      // Timer 2 has priority when both claim pin 7
      if (timer2_cmp_en)
         pb_out_next[`PBD_PIN_OC2] = timer2_compare_out;
      else if (timer1_cmp_c_en)
         pb_out_next[`PBD_PIN_OC2] = timer1_compare_c_out;
      // Master input: direction forced, output bit left as pull-up control.
      // As slave the direction bit decides whether the slave may talk.
      if (spi_enable && spi_master)
         pb_oe_next[`PBD_PIN_MISO] = 1'h0;
      else if (spi_enable)
         pb_out_next[`PBD_PIN_MISO] = spi_slave_out;
      // Serial clock drives only as an output; as input it is sampled below
      if (xck_active && portd_dir[`PBD_PIN_XCK])
         pd_out_next[`PBD_PIN_XCK] = serial2_clk_out;
      // Transmitter overrides the direction bit outright
      if (serial2_tx_en) begin
         pd_out_next[`PBD_PIN_TXD] = serial2_tx_data;
         pd_oe_next[`PBD_PIN_TXD]  = 1'h1;
      end
      // Receiver forces input; pull-up stays under the output bit
      if (serial2_rx_en)
         pd_oe_next[`PBD_PIN_RXD] = 1'h0;
      // Two-wire last: it detaches both pins from everything above
      if (two_wire_enable) begin
         // Open drain: output data fixed low, enable only pulls
         pd_out_next[`PBD_PIN_SCL] = 1'h0;
         pd_oe_next[`PBD_PIN_SCL]  = two_wire_scl_low;
         pd_out_next[`PBD_PIN_SDA] = 1'h0;
         pd_oe_next[`PBD_PIN_SDA]  = two_wire_sda_low;
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         portb_pad_out     <= `PBD_PORT_RST;
         portb_pad_oe      <= `PBD_PORT_RST;
         portb_pullup      <= `PBD_PORT_RST;
         portd_pad_out     <= `PBD_PORT_RST;
         portd_pad_oe      <= `PBD_PORT_RST;
         portd_pullup      <= `PBD_PORT_RST;
         portb_pin_val     <= `PBD_PORT_RST;
         portd_pin_val     <= `PBD_PORT_RST;
         ext_irq_line      <= 4'h0;
         // Receive line is high in reset, then reads low for two cycles while the low-reset synchronisers fill
         serial2_rx_pin    <= 1'h1;
         serial2_ext_clock <= 1'h0;
         timer1_capture_in <= 1'h0;
         spi_master_in     <= 1'h0;
         two_wire_sda_in   <= 1'h1;
         two_wire_scl_in   <= 1'h1;
      end else begin
         portb_pad_out <= pb_out_next;
         portb_pad_oe  <= pb_oe_next;
         portd_pad_out <= pd_out_next;
         portd_pad_oe  <= pd_oe_next;
         // Pull-up on any input pin follows its output bit, forced or not, except port D pins 0 and 1 while two_wire_enable is set
         portb_pullup  <= portb_out & ~pb_oe_next;
         portd_pullup  <= portd_out & ~pd_oe_next &
                          {6'h3F, {2{~two_wire_enable}}};
         portb_pin_val <= pb_s2_reg;
         portd_pin_val <= pd_s2_reg;
         ext_irq_line  <= pd_s2_reg[3:0];
         serial2_rx_pin <= pd_s2_reg[`PBD_PIN_RXD];
         serial2_ext_clock <= xck_active & pd_s2_reg[`PBD_PIN_XCK];
         timer1_capture_in <= pd_s2_reg[`PBD_PIN_XCK];
         spi_master_in <= pb_s2_reg[`PBD_PIN_MISO];
         // Filtered lines only; raw pad values would let spikes through
         two_wire_sda_in <= tw_in(two_wire_enable, filt_lvl[`PBD_PIN_SDA]);
         two_wire_scl_in <= tw_in(two_wire_enable, filt_lvl[`PBD_PIN_SCL]);
      end
   end

endmodule // pbd_mux

// ### sim/pbd_board.sv
// Board model for one 8-pin port
// Wired-AND pads, board pull-ups, optional external drivers
`timescale 1ns/1ps
module pbd_board (
   input  wire [7:0] pad_out, pad_oe, ext_val, ext_en,
   output wire [7:0] pad_in
);
   // A released line goes high on its pull-up
   assign pad_in = (~pad_oe | pad_out) & (~ext_en | ext_val);
endmodule // pbd_board

// ### sim/pbd_mux_monitor.sv
// Checker for the port B/D pin mux
// Bound into pbd_mux; sees only its ports
`timescale 1ns/1ps
module pbd_mon (
   input wire sys_clk, rst_n, serial2_tx_en, serial2_rx_en, serial2_sync_mode,
   input wire serial2_tx_data, serial2_clk_out, two_wire_enable, two_wire_scl_low,
   input wire spi_enable, spi_master, timer0_cmp_en, timer0_compare_out, timer1_capture_in,
   input wire [7:0] portb_dir, portb_out, portd_out, portd_dir, portd_pad_in,
   input wire [7:0] portb_pad_out, portb_pad_oe, portb_pullup, portd_pad_out, portd_pad_oe,
   input wire [7:0] portd_pullup,
   input wire [3:0] ext_irq_line
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   tx_drive_a: assert property (serial2_tx_en |=> portd_pad_oe[3] &&
      portd_pad_out[3] == $past(serial2_tx_data)) else $error("tx pin");
   rx_input_a: assert property (serial2_rx_en |=> !portd_pad_oe[2] &&
      portd_pullup[2] == $past(portd_out[2])) else $error("rx pin");
   xck_out_a: assert property (serial2_sync_mode && portd_dir[4] |=> portd_pad_oe[4] &&
      portd_pad_out[4] == $past(serial2_clk_out)) else $error("xck pin");
   scl_drain_a: assert property (two_wire_enable |=> !portd_pullup[0] &&
      portd_pad_oe[0] == $past(two_wire_scl_low) && !(portd_pad_oe[0] && portd_pad_out[0]))
      else $error("scl pin");
   miso_in_a: assert property (spi_enable && spi_master |=>
      !portb_pad_oe[3]) else $error("miso pin");
   cmp_zero_a: assert property (timer0_cmp_en |=> portb_pad_oe[4] == $past(portb_dir[4]) &&
      portb_pad_out[4] == $past(timer0_compare_out)) else $error("oc0 pin");
   gpio_pass_a: assert property ($past(rst_n) |-> portb_pad_oe[2:0] == $past(portb_dir[2:0]) &&
      portb_pullup[2:0] == $past(portb_out[2:0] & ~portb_dir[2:0])) else $error("gpio");
   pad_sync_a: assert property ($past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3) |->
      {timer1_capture_in, ext_irq_line} == $past(portd_pad_in[4:0], 3)) else $error("sync");
   cover property (serial2_tx_en && serial2_rx_en);
   cover property (two_wire_enable && two_wire_scl_low);
   cover property (spi_enable && !spi_master);
endmodule // pbd_mon
bind pbd_mux pbd_mon u_mon (.*);

// ### sim/testbench.sv
// Self-checking bench for the port B/D pin mux
// Board model on each port closes the pad loop
`timescale 1ns/1ps
module testbench;
   reg sys_clk = 1'h0, rst_n = 1'h0, serial2_tx_en = 1'h0, serial2_rx_en = 1'h0;
   reg serial2_sync_mode = 1'h0, serial2_tx_data = 1'h0, serial2_clk_out = 1'h0;
   reg two_wire_enable = 1'h0, two_wire_sda_low = 1'h0, two_wire_scl_low = 1'h0;
   reg spi_enable = 1'h0, spi_master = 1'h0, spi_slave_out = 1'h0, timer2_cmp_en = 1'h0;
   reg timer0_cmp_en = 1'h0, timer1_cmp_a_en = 1'h0, timer1_cmp_b_en = 1'h0;
   reg timer1_cmp_c_en = 1'h0, timer0_compare_out = 1'h0, timer1_compare_a_out = 1'h0;
   reg timer1_compare_b_out = 1'h0, timer1_compare_c_out = 1'h0, timer2_compare_out = 1'h0;
   reg [7:0] portb_dir = 8'h00, portb_out = 8'h00, portd_dir = 8'h00, portd_out = 8'h00;
   reg [7:0] d_en = 8'h00, d_val = 8'h00;
   wire [7:0] portb_pad_in, portd_pad_in, portb_pad_out, portb_pad_oe, portb_pullup;
   wire [7:0] portd_pad_out, portd_pad_oe, portd_pullup, portb_pin_val, portd_pin_val;
   wire [3:0] ext_irq_line;
   wire serial2_rx_pin, serial2_ext_clock, timer1_capture_in, spi_master_in;
   wire two_wire_sda_in, two_wire_scl_in;
   integer error_cnt = 0, cmp_count = 0;
   pbd_mux dut (.*);
   pbd_board brd_b (.pad_out(portb_pad_out), .pad_oe(portb_pad_oe), .ext_val(8'h00),
      .ext_en(8'h00), .pad_in(portb_pad_in));
   pbd_board brd_d (.pad_out(portd_pad_out), .pad_oe(portd_pad_oe), .ext_val(d_val),
      .ext_en(d_en), .pad_in(portd_pad_in));
   always #2.5 sys_clk = ~sys_clk;
   task chk(input [7:0] s, input [7:0] e, input [63:0] n);
      cmp_count = cmp_count + 1;
      if (s !== e) begin
         error_cnt = error_cnt + 1;
         $display("wrong value %0s exp %h saw %h", n, e, s);
      end
   endtask
   task go(input integer n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task t_serial;
      @(posedge sys_clk) {serial2_tx_en, serial2_rx_en, serial2_tx_data} <= 3'h7;
      @(posedge sys_clk) {portd_out, d_en} <= 16'h0404;
      go(5);
      chk({portd_pad_oe[3:2], portd_pad_out[3], portd_pullup[2]}, 8'h0B, "txrx");
      chk({serial2_rx_pin, ext_irq_line}, 8'h0B, "rx lo");
      chk(portd_pin_val, 8'hFB, "d pins");
      @(posedge sys_clk) {serial2_tx_data, d_en} <= 9'h000;
      go(5);
      chk({serial2_rx_pin, ext_irq_line}, 8'h17, "rx hi");
   endtask
   task t_xck;
      @(posedge sys_clk) {serial2_sync_mode, serial2_clk_out, portd_dir} <= 10'h310;
      go(2);
      chk({portd_pad_oe[4], portd_pad_out[4]}, 8'h03, "xck out");
      @(posedge sys_clk) {portd_dir, d_en} <= 16'h0010;
      go(5);
      chk({serial2_ext_clock, timer1_capture_in, portd_pad_oe[4]}, 8'h00, "xck lo");
      @(posedge sys_clk) d_val <= 8'h10;
      go(5);
      chk({serial2_ext_clock, timer1_capture_in}, 8'h03, "xck hi");
      @(posedge sys_clk) serial2_sync_mode <= 1'h0;
      go(4);
      chk({serial2_ext_clock, timer1_capture_in}, 8'h01, "async");
   endtask
   task t_twi;
      @(posedge sys_clk) {two_wire_enable, two_wire_scl_low, portd_out} <= 10'h303;
      go(20);
      chk({portd_pad_oe[1:0], portd_pad_oe[1:0] & portd_pad_out[1:0], portd_pullup[1:0],
         two_wire_scl_in}, 8'h20, "scl lo");
      @(posedge sys_clk) two_wire_scl_low <= 1'h0;
      go(20);
      chk(two_wire_scl_in, 8'h01, "scl hi");
      // 45 ns glitch must not pass
      @(posedge sys_clk) d_en <= 8'h11;
      repeat (9) @(posedge sys_clk);
      d_en <= 8'h10;
      repeat (20) begin
         go(1);
         chk(two_wire_scl_in, 8'h01, "spike");
      end
      @(posedge sys_clk) d_en <= 8'h11;
      go(20);
      chk(two_wire_scl_in, 8'h00, "long");
      @(posedge sys_clk) {two_wire_sda_low, d_en} <= 9'h110;
      go(20);
      chk({two_wire_sda_in, two_wire_scl_in}, 8'h01, "sda lo");
      @(posedge sys_clk) {two_wire_enable, two_wire_sda_low, d_en} <= 10'h010;
   endtask
   task t_port;
      @(posedge sys_clk) {portb_dir, portb_out, spi_enable, spi_master} <= 18'h3E43B;
      {timer0_cmp_en, timer1_cmp_a_en, timer1_cmp_b_en, timer1_cmp_c_en, timer2_cmp_en} <= 5'h1F;
      {timer2_compare_out, timer1_compare_b_out, timer0_compare_out} <= 3'h7;
      go(2);
      chk(portb_pad_oe, 8'hF1, "b oe");
      chk({portb_pad_out[7:4], portb_pullup[3:0]}, 8'hDE, "b out");
      @(posedge sys_clk) {timer2_cmp_en, timer0_compare_out, timer1_compare_a_out, spi_master,
         spi_slave_out} <= 5'h05;
      go(2);
      chk({portb_pad_out[7:3], portb_pad_oe[3]}, 8'h1B, "b slv");
      go(3);
      chk(portb_pin_val, 8'h6E, "b pins");
      chk(spi_master_in, 8'h01, "miso in");
   endtask
   task end_sim;
      $display("checks %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'h1;
      t_serial;
      t_xck;
      t_twi;
      t_port;
      end_sim;
   end
   initial begin
      #20000;
      error_cnt = error_cnt + 1;
      end_sim;
   end
endmodule // testbench
